// File: bench/qsw_host_model.sv
/* Host processor held in reset by channel 1; it kicks the watchdog.
 Assumes the bench enables kicking. */
`timescale 1ns/1ps
module qsw_host_model #(parameter int KICK_CYC = 20) (
	input wire logic clk,
	input wire logic kick_en,
	input wire logic supervisor_out_1_n,
	output logic     watchdog_kick
);
	int cnt = 0;
	initial watchdog_kick = 1'h0;
	// One kick edge a period, only while out of reset
	always @(posedge clk) begin
		cnt <= (!supervisor_out_1_n || cnt == KICK_CYC - 1) ? 0 : cnt + 1;
		if (kick_en && supervisor_out_1_n && cnt == KICK_CYC - 1) begin
			watchdog_kick <= #2 ~watchdog_kick;
		end
	end
endmodule : qsw_host_model

// File: bench/qsw_top_monitor.sv
/* Port checker for qsw_top.
 Assumes a bind onto qsw_top; a held fault reaches its output in 4 cycles. */
`timescale 1ns/1ps
module qsw_top_monitor #(parameter int unsigned WDT_CYC = 50) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic rail_monitor_1,
	input wire logic rail_monitor_2,
	input wire logic rail_monitor_4_under,
	input wire logic rail_monitor_4_over,
	input wire logic manual_hold_n,
	input wire logic supervisor_out_1_n,
	input wire logic supervisor_out_2_n,
	input wire logic supervisor_out_4_n,
	input wire logic watchdog_expired_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ch1_under: assert property (rail_monitor_1 [*5] |-> !supervisor_out_1_n)
		else $error("ch1 not held");
	a_ch2_under: assert property (rail_monitor_2 [*5] |-> !supervisor_out_2_n)
		else $error("ch2 not held");
	a_ch4_under: assert property (rail_monitor_4_under [*5] |-> !supervisor_out_4_n)
		else $error("ch4 under not held");
	a_ch4_over: assert property (rail_monitor_4_over [*5] |-> !supervisor_out_4_n)
		else $error("ch4 over not held");
	a_manual_hold: assert property (!manual_hold_n [*5] |-> !supervisor_out_1_n)
		else $error("hold ignored");
	a_wdo_sticky: assert property (!watchdog_expired_n |=> !watchdog_expired_n)
		else $error("timeout left");
	a_wdo_after_release: assert property ($fell(watchdog_expired_n) |-> $past(supervisor_out_1_n, 3))
		else $error("timeout in reset");
	a_reset_state: assert property ($rose(nrst) |-> !supervisor_out_1_n &&
		!supervisor_out_2_n && !supervisor_out_4_n && watchdog_expired_n)
		else $error("bad reset state");
endmodule : qsw_top_monitor
bind qsw_top qsw_top_monitor #(.WDT_CYC(WDT_CYC)) mon_u (.clk(clk), .nrst(nrst),
	.rail_monitor_1(rail_monitor_1), .rail_monitor_2(rail_monitor_2),
	.rail_monitor_4_under(rail_monitor_4_under), .rail_monitor_4_over(rail_monitor_4_over),
	.manual_hold_n(manual_hold_n), .supervisor_out_1_n(supervisor_out_1_n),
	.supervisor_out_2_n(supervisor_out_2_n), .supervisor_out_4_n(supervisor_out_4_n),
	.watchdog_expired_n(watchdog_expired_n));

// File: bench/tb_top.sv
/* Self-checking bench for qsw_top.
 Assumes the host model kicks the watchdog; watchdog period shortened. */
`timescale 1ns/1ps
module tb_top;
	import qsw_pkg::*;
	typedef struct {logic [4:0] v; int c; int tol;} qsw_note_t;
	localparam int WDT = 50;
	logic clk = 0, nrst = 0, kick_en = 0;
	wire kick;
	wire [4:0] outs;
	logic [5:0] flt = 0;
	qsw_sel_t sel3 = QSW_SEL_CAP;
	logic [`QSW_CNT_W-1:0] d [4];
	logic [4:0] last = 5'h01, exp_v;
	int cyc = 0, seed = 83607, num_errors = 0, samples_checked = 0;
	qsw_note_t q[$], n;
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	qsw_top #(.WDT_CYC(WDT)) dut_u (.clk(clk), .nrst(nrst), .rail_monitor_1(flt[0]),
		.rail_monitor_2(flt[1]), .rail_monitor_3(flt[2]), .rail_monitor_4_under(flt[3]),
		.rail_monitor_4_over(flt[4]), .manual_hold_n(~flt[5]), .watchdog_kick(kick),
		.delay_select_1(QSW_SEL_CAP), .delay_select_2(QSW_SEL_CAP), .delay_select_3(sel3),
		.delay_select_4(QSW_SEL_CAP), .prog_delay_1(d[0]), .prog_delay_2(d[1]),
		.prog_delay_3(d[2]), .prog_delay_4(d[3]), .supervisor_out_1_n(outs[4]),
		.supervisor_out_2_n(outs[3]), .supervisor_out_3_n(outs[2]),
		.supervisor_out_4_n(outs[1]), .watchdog_expired_n(outs[0]));
	qsw_host_model host_u (.clk(clk), .kick_en(kick_en), .supervisor_out_1_n(outs[4]),
		.watchdog_kick(kick));
	task automatic cmp(input string nm, input logic [4:0] e, input logic [4:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp
	task automatic expect_at(input int c, input int tol);
		q.push_back('{exp_v, c, tol});
	endtask : expect_at
	task automatic wait_q;
		for (int i = 0; i < 4000 && q.size() > 0; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		#2;
	endtask : wait_q
	task automatic powerup;
		#2 nrst = 1'h1;
		exp_v = 5'h01;
		for (int i = 0; i < 4; i++) begin
			exp_v[4 - i] = 1'h1;
			expect_at(cyc + 2 + d[i], 2);
		end
		wait_q();
	endtask : powerup
	task automatic pulse(input int k, input int hold, input bit rel);
		int ch;
		ch = (k == 5) ? 0 : (k == 4) ? 3 : k;
		flt[k] = 1'h1;
		exp_v[4 - ch] = 1'h0;
		expect_at(cyc + 4, 1);
		repeat (hold) @(posedge clk);
		#2 flt[k] = 1'h0;
		if (rel) begin
			exp_v[4 - ch] = 1'h1;
			expect_at(cyc + 3 + d[ch], 1);
		end
		wait_q();
	endtask : pulse
	task automatic give_verdict;
		num_errors += q.size();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	// Each output change takes the oldest note
	always @(posedge clk) begin
		#1;
		if (outs !== last) begin
			last = outs;
			if (q.size() == 0) begin
				cmp("unexpected", last, ~last);
			end else begin
				n = q.pop_front();
				cmp("outputs", n.v, outs);
				cmp("cycle", 5'h01, {4'h0, cyc - n.c <= n.tol && n.c - cyc <= n.tol});
			end
		end
	end
	initial begin
		#(25 * 10000);
		num_errors++;
		give_verdict();
	end
	initial begin
		for (int i = 0; i < 4; i++)
			d[i] = 10 * (i + 1) + $unsigned($random(seed)) % 4;
		repeat (20) @(posedge clk);
		powerup();
		kick_en = 1'h1;
		for (int k = 0; k < 6; k++)
			pulse(k, 5 + $unsigned($random(seed)) % 8, 1);
		sel3 = QSW_SEL_OPEN;
		pulse(2, 6, 0);
		repeat (200) @(posedge clk);
		#2 kick_en = 1'h0;
		exp_v[0] = 1'h0;
		expect_at(cyc + WDT - 7, 14);
		wait_q();
		kick_en = 1'h1;
		pulse(0, 6, 1);
		sel3 = QSW_SEL_CAP;
		nrst = 1'h0;
		exp_v = 5'h01;
		expect_at(cyc + 1, 1);
		repeat (3) @(posedge clk);
		powerup();
		give_verdict();
	end
endmodule : tb_top

// File: core/qsw_chan.sv
/*
 One supervisor channel: holds its active-low output while the fault stands,
 then for the selected delay. Assumes fault is already synchronised.
*/
`timescale 1ns/1ps

module qsw_chan (
	input  wire logic  clk,
	input  wire logic  nrst,
	qsw_chan_if.chan   cif
);
	import qsw_pkg::*;

	typedef struct packed {
		qsw_chan_st_t          st;
		logic [`QSW_CNT_W-1:0] cnt;
		logic                  out_n;
	} qsw_chan_state_t;

	qsw_chan_state_t s_r;
	qsw_chan_state_t s_nxt;
	logic [`QSW_CNT_W-1:0] delay_cyc;

	always_comb begin
		case (cif.sel)
			QSW_SEL_OPEN: delay_cyc = `QSW_CNT_W'(`QSW_FIXED_OPEN_CYC);
			QSW_SEL_HIGH: delay_cyc = `QSW_CNT_W'(`QSW_FIXED_HIGH_CYC);
			default:      delay_cyc = (cif.prog_cyc == '0) ? `QSW_CNT_W'(1) : cif.prog_cyc;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			QSW_ST_HOLD: begin
				s_nxt.out_n = 1'b0;
				if (cif.fault) begin
					s_nxt.cnt = '0;
				end else if (s_r.cnt + `QSW_CNT_W'(1) >= delay_cyc) begin
					s_nxt.st    = QSW_ST_RELEASED;
					s_nxt.out_n = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt + `QSW_CNT_W'(1);
				end
			end
			default: begin
				if (cif.fault) begin
					s_nxt.st    = QSW_ST_HOLD;
					s_nxt.cnt   = '0;
					s_nxt.out_n = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '{st: QSW_ST_HOLD, cnt: '0, out_n: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cif.out_n = s_r.out_n;
endmodule : qsw_chan

// File: core/qsw_chan_if.sv
/*
 Interface between the top module and one supervisor channel.
 Assumes the top drives condition and delay setting, the channel drives its output.
*/
`timescale 1ns/1ps

interface qsw_chan_if;
	import qsw_pkg::*;
	logic                    fault;
	qsw_pkg::qsw_sel_t       sel;
	logic [`QSW_CNT_W-1:0]   prog_cyc;
	logic                    out_n;
	modport top  (output fault, output sel, output prog_cyc, input out_n);
	modport chan (input fault, input sel, input prog_cyc, output out_n);
endinterface : qsw_chan_if

// File: core/qsw_defines.svh
/*
 Timing constants and reset values for the quad supervisor with watchdog.
 Assumes a 40 MHz clock; all delays become cycle counts of that clock.
*/
`ifndef QSW_DEFINES_SVH
`define QSW_DEFINES_SVH

`define QSW_CLK_HZ          40000000
`define QSW_FIXED_OPEN_MS   20
`define QSW_FIXED_HIGH_MS   300
`define QSW_WDT_MS          600
`define QSW_FIXED_OPEN_CYC  ((`QSW_FIXED_OPEN_MS * (`QSW_CLK_HZ / 1000)))
`define QSW_FIXED_HIGH_CYC  ((`QSW_FIXED_HIGH_MS * (`QSW_CLK_HZ / 1000)))
`define QSW_WDT_CYC         ((`QSW_WDT_MS * (`QSW_CLK_HZ / 1000)))
`define QSW_CNT_W           32
`define QSW_SYNC_RST        1'h1

`endif

// File: core/qsw_pkg.sv
/*
 Types shared by the supervisor channel and the top module.
 Assumes qsw_defines.svh is on the include path.
*/
`include "qsw_defines.svh"

package qsw_pkg;
	typedef enum logic [1:0] {
		QSW_SEL_OPEN,
		QSW_SEL_HIGH,
		QSW_SEL_CAP
	} qsw_sel_t;

	typedef enum logic {
		QSW_ST_HOLD,
		QSW_ST_RELEASED
	} qsw_chan_st_t;

	typedef enum logic [1:0] {
		QSW_WD_IDLE,
		QSW_WD_RUN,
		QSW_WD_EXPIRED
	} qsw_wd_st_t;
endpackage : qsw_pkg

// File: core/qsw_top.sv
/*
 Quad supply supervisor with watchdog: four delayed reset channels and a
 watchdog timeout output. Assumes digitised comparator flags from analog logic
 and a 40 MHz clock; open-drain drive is done by pads outside.
*/
`timescale 1ns/1ps

// Contract
// - Channels 1 to 3 assert reset while their rail is under threshold.
// - Channel 4 asserts reset while its falling monitor is under threshold.
// - Channel 4 also asserts reset while its rising monitor is over threshold.
// - Low manual hold input asserts channel 1 reset regardless of rail.
// - Open or tied-high delay select chooses a fixed release delay.
// - Capacitor delay select chooses a programmable delay from configured value.
// - Reset outputs are active low, driven low while condition holds.
// - After condition clears, output stays low for delay then releases.
// - Any kick edge restarts watchdog; timing starts at channel 1 release.
// - On watchdog expiry the timeout output is driven low.
// - Without timeout the watchdog output stays released.
// - Watchdog period is nominally 600 ms from release or last kick.
// - Once expired, timeout output stays low regardless of kicks or channel 1 reset; only nrst releases it.
module qsw_top #(
	parameter int unsigned WDT_CYC = `QSW_WDT_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   rail_monitor_1,
	input  wire logic                   rail_monitor_2,
	input  wire logic                   rail_monitor_3,
	input  wire logic                   rail_monitor_4_under,
	input  wire logic                   rail_monitor_4_over,
	input  wire logic                   manual_hold_n,
	input  wire logic                   watchdog_kick,
	input  wire qsw_pkg::qsw_sel_t      delay_select_1,
	input  wire qsw_pkg::qsw_sel_t      delay_select_2,
	input  wire qsw_pkg::qsw_sel_t      delay_select_3,
	input  wire qsw_pkg::qsw_sel_t      delay_select_4,
	input  wire logic [`QSW_CNT_W-1:0]  prog_delay_1,
	input  wire logic [`QSW_CNT_W-1:0]  prog_delay_2,
	input  wire logic [`QSW_CNT_W-1:0]  prog_delay_3,
	input  wire logic [`QSW_CNT_W-1:0]  prog_delay_4,
	output logic                        supervisor_out_1_n,
	output logic                        supervisor_out_2_n,
	output logic                        supervisor_out_3_n,
	output logic                        supervisor_out_4_n,
	output logic                        watchdog_expired_n
);
	import qsw_pkg::*;

	localparam int NSYNC = 7;

	typedef struct packed {
		logic [NSYNC-1:0]      sync1;
		logic [NSYNC-1:0]      sync2;
		logic                  kick_d;
		logic                  rel1_d;
		qsw_wd_st_t            wd_st;
		logic [`QSW_CNT_W-1:0] wd_cnt;
		logic [3:0]            out_n;
		logic                  wdo_n;
	} qsw_top_state_t;

	qsw_top_state_t s_r;
	qsw_top_state_t s_nxt;
	logic [NSYNC-1:0] raw_in;
	logic [3:0]       fault;
	logic [3:0]       chan_out_n;
	logic             kick_edge;
	logic             rel1_rise;

	qsw_chan_if cif [4] ();

	assign raw_in = {watchdog_kick, manual_hold_n, rail_monitor_4_over,
		rail_monitor_4_under, rail_monitor_3, rail_monitor_2, rail_monitor_1};

	// Flags are 1 when the comparator trips: under threshold, or over for 4 over
	assign fault[0] = s_r.sync2[0] | ~s_r.sync2[5];
	assign fault[1] = s_r.sync2[1];
	assign fault[2] = s_r.sync2[2];
	assign fault[3] = s_r.sync2[3] | s_r.sync2[4];

	assign cif[0].sel      = delay_select_1;
	assign cif[1].sel      = delay_select_2;
	assign cif[2].sel      = delay_select_3;
	assign cif[3].sel      = delay_select_4;
	assign cif[0].prog_cyc = prog_delay_1;
	assign cif[1].prog_cyc = prog_delay_2;
	assign cif[2].prog_cyc = prog_delay_3;
	assign cif[3].prog_cyc = prog_delay_4;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			assign cif[gi].fault = fault[gi];
			assign chan_out_n[gi] = cif[gi].out_n;
			qsw_chan u_chan (
				.clk  (clk),
				.nrst (nrst),
				.cif  (cif[gi])
			);
		end
	endgenerate

	assign kick_edge = s_r.sync2[6] ^ s_r.kick_d;
	assign rel1_rise = chan_out_n[0] & ~s_r.rel1_d;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.sync1  = raw_in;
		s_nxt.sync2  = s_r.sync1;
		s_nxt.kick_d = s_r.sync2[6];
		s_nxt.rel1_d = chan_out_n[0];
		s_nxt.out_n  = chan_out_n;
		case (s_r.wd_st)
			QSW_WD_IDLE: begin
				s_nxt.wdo_n = 1'b1;
				if (rel1_rise) begin
					s_nxt.wd_st  = QSW_WD_RUN;
					s_nxt.wd_cnt = '0;
				end
			end
			QSW_WD_RUN: begin
				if (!chan_out_n[0]) begin
					s_nxt.wd_st = QSW_WD_IDLE;
				end else if (kick_edge) begin
					s_nxt.wd_cnt = '0;
				end else if (s_r.wd_cnt + `QSW_CNT_W'(1) >= `QSW_CNT_W'(WDT_CYC)) begin
					s_nxt.wd_st = QSW_WD_EXPIRED;
					s_nxt.wdo_n = 1'b0;
				end else begin
					s_nxt.wd_cnt = s_r.wd_cnt + `QSW_CNT_W'(1);
				end
			end
			default: begin
				s_nxt.wdo_n = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// Manual hold stages start at its idle high level, so no false hold follows reset
			s_r <= '{sync1: 7'h20, sync2: 7'h20, kick_d: 1'b0, rel1_d: 1'b0,
				wd_st: QSW_WD_IDLE, wd_cnt: '0, out_n: 4'h0, wdo_n: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign supervisor_out_1_n = s_r.out_n[0];
	assign supervisor_out_2_n = s_r.out_n[1];
	assign supervisor_out_3_n = s_r.out_n[2];
	assign supervisor_out_4_n = s_r.out_n[3];
	assign watchdog_expired_n = s_r.wdo_n;
endmodule : qsw_top
